// File: owt_pkg.sv
package owt_pkg;

  // ********************************************************
  // Counter geometry and timing
  // ********************************************************
  localparam int unsigned PRE_WIDTH = 12;
  localparam int unsigned WD_WIDTH = 6;
  localparam int unsigned SHORT_TAP = 6;          // Carry of bits 6..0 gives 2^13 total
  localparam int unsigned CLEAR_LOW_BIT = 4;      // Prescaler bits from here up are cleared
  localparam int unsigned RESET_PULSE_TICKS = 32; // Crystal clocks of reset pin low
  localparam int unsigned APB_ADDR_WIDTH = 18;

  // ********************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [15:0] CLEAR_IDX = 16'hffff;
  localparam logic [15:0] STATUS_IDX = 16'h0000;
  localparam logic [15:0] COUNT_IDX = 16'h0001;

  // ********************************************************
  // Field positions and reset values
  // ********************************************************
  localparam int unsigned CAUSE_BIT = 0;
  localparam int unsigned ENABLE_BIT = 1;
  localparam int unsigned PULSE_BIT = 2;
  localparam int unsigned VECTOR_LSB = 0;
  localparam int unsigned WD_COUNT_LSB = 0;
  localparam int unsigned PRE_COUNT_LSB = 16;
  localparam logic CAUSE_RESET = 1'b0;
  localparam logic ENABLE_RESET = 1'b1;

  typedef enum logic [1:0] {
    OWT_RUN = 2'b00,
    OWT_PULSE = 2'b01,
    OWT_HOLD = 2'b10
  } owt_state_t;

  typedef enum logic [1:0] {
    OWT_SEL_NONE = 2'b00,
    OWT_SEL_CLEAR = 2'b01,
    OWT_SEL_STATUS = 2'b10,
    OWT_SEL_COUNT = 2'b11
  } owt_sel_t;

endpackage

// File: owt_watchdog.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module owt_watchdog
  import owt_pkg::*;
#(
  parameter int unsigned PRE_W = PRE_WIDTH,
  parameter int unsigned WD_W = WD_WIDTH,
  parameter int unsigned ADDR_W = APB_ADDR_WIDTH,
  parameter int unsigned PULSE_TICKS = RESET_PULSE_TICKS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_clock_tick,
  input wire logic stop_exec,
  input wire logic stop_mode,
  input wire logic internal_reset,
  input wire logic reset_vector_fetch,
  input wire logic monitor_mode,
  input wire logic break_state,
  input wire logic overvoltage_level_on_reset_pin,
  input wire logic overvoltage_level_on_irq_pin,
  input wire logic watchdog_disable_option,
  input wire logic short_timeout_option,
  input wire logic [7:0] reset_vector_low,
  input wire logic reset_accept,
  output logic reset_pin_n,
  output logic reset_request,
  output logic watchdog_enable
);

  // ********************************************************
  // Elaboration checks
  // ********************************************************
  if (PRE_W <= SHORT_TAP + 1 || PRE_W <= CLEAR_LOW_BIT || PRE_W + PRE_COUNT_LSB > 32) begin
    $error("owt_watchdog: prescaler width not supported");
  end
  if (WD_W < 1 || WD_W > PRE_COUNT_LSB || ADDR_W < 18 || ADDR_W > 32) begin
    $error("owt_watchdog: counter or address width not supported");
  end
  if (PULSE_TICKS < 2 || PULSE_TICKS > 255) begin
    $error("owt_watchdog: reset pulse length not supported");
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  // Prescaler carry into the watchdog counter, tap chosen by the timeout option
  function automatic logic tap_wrap(input logic [PRE_W-1:0] pre, input logic short_sel);
    logic hit;
    hit = short_sel ? (pre == {PRE_W{1'b1}}) : (pre[SHORT_TAP:0] == {(SHORT_TAP+1){1'b1}});
    return hit;
  endfunction

  // Word decode; registers sit at four times their index
  function automatic owt_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    owt_sel_t s;
    s = OWT_SEL_NONE;
    if (a == ADDR_W'({CLEAR_IDX, 2'b00})) begin
      s = OWT_SEL_CLEAR;
    end else if (a == ADDR_W'({STATUS_IDX, 2'b00})) begin
      s = OWT_SEL_STATUS;
    end else if (a == ADDR_W'({COUNT_IDX, 2'b00})) begin
      s = OWT_SEL_COUNT;
    end
    return s;
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [WD_W-1:0] wd_q, wd_d;
  owt_state_t st_q, st_d;
  logic [7:0] pulse_q, pulse_d;
  logic req_q, req_d;
  logic cause_q, cause_d;
  logic pin_n_q, pin_n_d;
  logic enable_q, enable_d;
  logic stop_seen_q, stop_seen_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic hv_disable;
  logic count_tick;
  logic wr_done;
  logic clr_wr;
  logic cause_clr;
  logic ovf;
  logic fire;

  // Overvoltage disable is a live level, so removal re-enables at once
  assign hv_disable = (monitor_mode && (overvoltage_level_on_reset_pin ||
                      overvoltage_level_on_irq_pin)) ||
                      (break_state && overvoltage_level_on_reset_pin);
  // Stop gates the crystal tick; wait mode has no gate at all
  assign count_tick = crystal_clock_tick && !stop_mode;
  assign wr_done = psel && penable && pready_q && pwrite;
  // Any data value services the watchdog
  assign clr_wr = wr_done && (reg_sel(paddr) == OWT_SEL_CLEAR);
  assign cause_clr = wr_done && (reg_sel(paddr) == OWT_SEL_STATUS) && pstrb[0] &&
                     pwdata[CAUSE_BIT];

  // ********************************************************
  // Prescaler and watchdog counter
  // ********************************************************
  // Clears are applied after the count so a same-cycle clear always wins
  always_comb begin
    pre_d = pre_q;
    wd_d = wd_q;
    ovf = 1'b0;
    stop_seen_d = stop_mode;
    if (st_q != OWT_RUN || internal_reset || hv_disable) begin
      pre_d = '0;
      wd_d = '0;
    end else begin
      if (count_tick) begin
        pre_d = pre_q + 1'b1;
        if (tap_wrap(pre_q, short_timeout_option)) begin
          wd_d = wd_q + 1'b1;
          ovf = (wd_q == {WD_W{1'b1}}) && !clr_wr;
        end
      end
      if (clr_wr) begin
        wd_d = '0;
        pre_d[PRE_W-1:CLEAR_LOW_BIT] = '0;
      end
      if (stop_exec || (stop_mode && !stop_seen_q) || reset_vector_fetch) begin
        pre_d = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      wd_q <= '0;
      stop_seen_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      wd_q <= wd_d;
      stop_seen_q <= stop_seen_d;
    end
  end

  // ********************************************************
  // Reset pulse sequencer
  // ********************************************************
  // The option gate sits at the very end, so no path can leak a reset
  assign fire = ovf && !watchdog_disable_option;

  // No interrupt path exists; the reset pin and request are the only actions
  always_comb begin
    st_d = st_q;
    pulse_d = pulse_q;
    req_d = req_q;
    cause_d = cause_q;
    enable_d = !hv_disable;
    if (reset_accept) begin
      req_d = 1'b0;
    end
    if (cause_clr) begin
      cause_d = 1'b0;
    end
    case (st_q)
      OWT_RUN: begin
        if (fire) begin
          st_d = OWT_PULSE;
          pulse_d = '0;
          req_d = 1'b1;   // Set wins over a same-cycle accept
          cause_d = 1'b1; // Set wins over a same-cycle software clear
        end
      end
      OWT_PULSE: begin
        if (crystal_clock_tick) begin
          pulse_d = pulse_q + 1'b1;
          if (pulse_q == 8'(PULSE_TICKS - 1)) begin
            st_d = req_d ? OWT_HOLD : OWT_RUN;
          end
        end
      end
      OWT_HOLD: begin
        if (!req_d) begin
          st_d = OWT_RUN;
        end
      end
      default: begin
        st_d = OWT_RUN;
      end
    endcase
    pin_n_d = (st_d != OWT_PULSE);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= OWT_RUN;
      pulse_q <= '0;
      req_q <= 1'b0;
      cause_q <= CAUSE_RESET;
      pin_n_q <= 1'b1;
      enable_q <= ENABLE_RESET;
    end else begin
      st_q <= st_d;
      pulse_q <= pulse_d;
      req_q <= req_d;
      cause_q <= cause_d;
      pin_n_q <= pin_n_d;
      enable_q <= enable_d;
    end
  end

  // ********************************************************
  // APB slave
  // ********************************************************
  // One wait state buys registered read data and response flags
  always_comb begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      prdata_d = '0;
      case (reg_sel(paddr))
        OWT_SEL_CLEAR: begin
          if (!pwrite) begin
            prdata_d[VECTOR_LSB +: 8] = reset_vector_low;
          end
        end
        OWT_SEL_STATUS: begin
          if (!pwrite) begin
            prdata_d[CAUSE_BIT] = cause_q;
            prdata_d[ENABLE_BIT] = enable_q;
            prdata_d[PULSE_BIT] = !pin_n_q;
          end
        end
        OWT_SEL_COUNT: begin
          if (!pwrite) begin
            prdata_d[WD_COUNT_LSB +: WD_W] = wd_q;
            prdata_d[PRE_COUNT_LSB +: PRE_W] = pre_q;
          end
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign reset_pin_n = pin_n_q;
  assign reset_request = req_q;
  assign watchdog_enable = enable_q;

  // ********************************************************
  // Assertions
  // ********************************************************
  // Helper: crystal ticks seen while the reset pin is low
  logic [7:0] low_ticks_q, low_ticks_d;

  always_comb begin
    low_ticks_d = '0;
    if (!pin_n_q) begin
      low_ticks_d = low_ticks_q + 8'(crystal_clock_tick);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_ticks_q <= '0;
    end else begin
      low_ticks_q <= low_ticks_d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_overflow;
    st_q == OWT_RUN && !hv_disable && !internal_reset && count_tick && !clr_wr &&
      wd_q == {WD_W{1'b1}} && tap_wrap(pre_q, short_timeout_option);
  endsequence

  sequence s_clear_read;
    psel && penable && !pready_q && !pwrite && reg_sel(paddr) == OWT_SEL_CLEAR;
  endsequence

  property p_overflow_reset;
    s_overflow ##0 !watchdog_disable_option |=> !reset_pin_n && reset_request;
  endproperty
  a_overflow_reset: assert property (p_overflow_reset) else $error("no reset on overflow");

  property p_clear_write;
    clr_wr && !internal_reset && !hv_disable && st_q == OWT_RUN |=>
      wd_q == '0 && pre_q[PRE_W-1:CLEAR_LOW_BIT] == '0;
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("clear write missed");

  property p_clear_read;
    s_clear_read |=> pready && prdata == {24'h0, $past(reset_vector_low)};
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("clear read not vector");

  property p_pulse_len;
    $rose(reset_pin_n) |-> low_ticks_q == 8'(PULSE_TICKS);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  property p_cause_set;
    $fell(reset_pin_n) |-> cause_q && reset_request;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause flag not set");

  property p_hv_disable;
    hv_disable |=> !watchdog_enable && wd_q == '0 && pre_q == '0;
  endproperty
  a_hv_disable: assert property (p_hv_disable) else $error("overvoltage disable failed");

  property p_break_hv;
    break_state && overvoltage_level_on_reset_pin && st_q == OWT_RUN |=> reset_pin_n;
  endproperty
  a_break_hv: assert property (p_break_hv) else $error("reset during break disable");

  property p_hv_release;
    !hv_disable |=> watchdog_enable;
  endproperty
  a_hv_release: assert property (p_hv_release) else $error("enable not restored");

  property p_option_block;
    st_q == OWT_RUN && watchdog_disable_option |=> st_q != OWT_PULSE;
  endproperty
  a_option_block: assert property (p_option_block) else $error("disabled reset fired");

  property p_stop_clear;
    stop_exec || reset_vector_fetch || internal_reset |=> pre_q == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("prescaler not cleared");

  property p_internal_reset;
    internal_reset |=> wd_q == '0 ##1 (st_q != OWT_RUN || wd_q <= 1);
  endproperty
  a_internal_reset: assert property (p_internal_reset) else $error("counter survived");

  property p_stop_freeze;
    stop_mode && st_q == OWT_RUN && !clr_wr && !internal_reset && !hv_disable |=>
      $stable(wd_q);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("count moved in stop");

  property p_request_hold;
    reset_request && !reset_accept |=> reset_request;
  endproperty
  a_request_hold: assert property (p_request_hold) else $error("request dropped");

  property p_restart_zero;
    st_q == OWT_RUN && $past(st_q) != OWT_RUN |-> wd_q == '0 && pre_q == '0;
  endproperty
  a_restart_zero: assert property (p_restart_zero) else $error("no zero restart");

endmodule

// File: operating_watchdog_timer_test.sv
`timescale 1ns/1ns
module operating_watchdog_timer_test;
  import owt_pkg::*;
  // ****************************************
  // Stimulus signals
  // ****************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic tick = 1'b0, stop_exec = 1'b0, stop_mode = 1'b0, internal_reset = 1'b0;
  logic vec_fetch = 1'b0, monitor_mode = 1'b0, break_state = 1'b0;
  logic ov_rst = 1'b0, ov_irq = 1'b0, dis_opt = 1'b0, short_opt = 1'b0;
  logic [7:0] vec_low = 8'h5a;
  logic reset_accept = 1'b0;
  logic reset_pin_n, reset_request, watchdog_enable;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic err;
  localparam logic [17:0] A_CLR = {CLEAR_IDX, 2'b00};
  localparam logic [17:0] A_STS = {STATUS_IDX, 2'b00};
  localparam logic [17:0] A_CNT = {COUNT_IDX, 2'b00};

  owt_watchdog dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_clock_tick(tick), .stop_exec(stop_exec),
    .stop_mode(stop_mode), .internal_reset(internal_reset), .reset_vector_fetch(vec_fetch),
    .monitor_mode(monitor_mode), .break_state(break_state),
    .overvoltage_level_on_reset_pin(ov_rst), .overvoltage_level_on_irq_pin(ov_irq),
    .watchdog_disable_option(dis_opt), .short_timeout_option(short_opt),
    .reset_vector_low(vec_low), .reset_accept(reset_accept), .reset_pin_n(reset_pin_n),
    .reset_request(reset_request), .watchdog_enable(watchdog_enable));

  // Free-running system clock, 20 ns period
  always #10 clock = ~clock;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // APB master: holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No cycle count is assumed; only the bench watchdog ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Exactly n one-cycle crystal ticks, then ticks stop
  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge clock);
      tick <= 1'b1;
    end
    @(posedge clock);
    tick <= 1'b0;
  endtask

  task automatic ireset();
    @(posedge clock);
    internal_reset <= 1'b1;
    @(posedge clock);
    internal_reset <= 1'b0;
  endtask

  function automatic logic [31:0] cnt(input int pre, input int wd);
    return {4'h0, pre[11:0], 10'h0, wd[5:0]};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_and_read();
    check({29'h0, reset_pin_n, reset_request, watchdog_enable}, 32'h5, "reset pins");
    apb(1'b0, A_STS, 32'h0);
    check(rd, 32'h2, "status after reset");
    check({31'h0, err}, 32'h0, "mapped no error");
    apb(1'b0, A_CLR, 32'h0);
    check(rd, {24'h0, vec_low}, "clear read");
    apb(1'b0, 18'h00100, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
  endtask

  // Counting, servicing and the clock source of timing
  task automatic t_count();
    tick_n(395);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(395, 3), "short count");
    repeat (20) @(posedge clock);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(395, 3), "no count without tick");
    apb(1'b1, A_CLR, 32'h0000_00c3); // service from the main flow
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(395 & 15, 0), "service clear");
    ireset();
    short_opt <= 1'b1;
    tick_n(4100);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(4, 1), "long count");
    short_opt <= 1'b0;
    ireset();
  endtask

  // Stop, stop mode, vector fetch and internal reset clears
  task automatic t_clears();
    tick_n(395);
    @(posedge clock);
    stop_exec <= 1'b1;
    @(posedge clock);
    stop_exec <= 1'b0;
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(0, 3), "stop clears prescaler");
    tick_n(20);
    stop_mode <= 1'b1;
    tick_n(50);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(0, 3), "stop mode freeze");
    stop_mode <= 1'b0;
    tick_n(20);
    @(posedge clock);
    vec_fetch <= 1'b1;
    @(posedge clock);
    vec_fetch <= 1'b0;
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(0, 3), "vector fetch");
    ireset();
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(0, 0), "internal reset");
  endtask

  // Overvoltage disable by mode; irq pin counts only in monitor mode
  task automatic t_overvoltage();
    logic [3:0] cfg [4] = '{4'b1010, 4'b1001, 4'b0110, 4'b0101};
    logic en_exp [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {monitor_mode, break_state, ov_rst, ov_irq} <= cfg[i];
      repeat (3) @(posedge clock);
      check({31'h0, watchdog_enable}, {31'h0, en_exp[i]}, "enable");
      tick_n(200);
      apb(1'b0, A_CNT, 32'h0);
      check(rd, en_exp[i] ? cnt(200, 1) : 32'h0, "count while disabled");
      {monitor_mode, break_state, ov_rst, ov_irq} <= 4'b0;
      repeat (3) @(posedge clock);
      check({31'h0, watchdog_enable}, 32'h1, "enable restored");
      ireset();
    end
  endtask

  // Overflow: timeout, 32-cycle pin pulse, cause flag, held request
  task automatic t_overflow();
    int n;
    int m;
    ireset();
    apb(1'b1, A_CLR, 32'h0); // service right after reset
    @(posedge clock);
    tick <= 1'b1;
    stop_exec <= 1'b0; // stop stays low so it cannot clear the prescaler
    n = 0;
    while (reset_pin_n === 1'b1 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, n >= 8176 && n <= 8200}, 32'h1, "timeout length");
    m = 0;
    while (reset_pin_n === 1'b0 && m < 100) begin
      @(posedge clock);
      m++;
    end
    check(m, 32, "reset pulse length");
    tick <= 1'b0;
    check({31'h0, reset_request}, 32'h1, "request held");
    apb(1'b0, A_STS, 32'h0);
    check(rd, 32'h3, "cause flag");
    @(posedge clock);
    reset_accept <= 1'b1;
    @(posedge clock);
    reset_accept <= 1'b0;
    repeat (2) @(posedge clock);
    check({31'h0, reset_request}, 32'h0, "request released");
    tick_n(10);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, cnt(10, 0), "restart from zero");
    apb(1'b1, A_STS, 32'h1);
    apb(1'b0, A_STS, 32'h0);
    check(rd, 32'h2, "cause cleared");
  endtask

  // Disable option blocks the reset while counting goes on
  task automatic t_disable();
    dis_opt <= 1'b1;
    ireset();
    tick_n(8300);
    check({30'h0, reset_request, reset_pin_n}, 32'h1, "no reset when disabled");
    apb(1'b0, A_STS, 32'h0);
    check(rd, 32'h2, "no cause when disabled");
    dis_opt <= 1'b0;
    ireset();
  endtask

  // ****************************************
  // Verdict and run control
  // ****************************************
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog on the bench itself: the run needs well under 40000 cycles
  initial begin
    #1000000;
    n_errors++;
    $display("MISMATCH %0t bench timeout", $time);
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset_and_read();
    t_count();
    t_clears();
    t_overvoltage();
    t_overflow();
    t_disable();
    give_verdict();
  end
endmodule
